// ---- ivp_defs.vh ----
// vector placement constants: offsets, widths, reset values
// assumes 12-bit word program addresses
`ifndef IVP_DEFS_VH
`define IVP_DEFS_VH
`define IVP_AW 12
`define IVP_NSRC 25
`define IVP_RESET_OFS 12'h000
`define IVP_TABLE_OFS 12'h001
`define IVP_BOOT_START_DEF 12'hC00
`define IVP_FUSE_PROGRAMMED 1'b0
`define IVP_SEL_RST 1'b0
`define IVP_ZERO_BASE 12'h000
`define IVP_NUM_OFS 5'h02
`define IVP_NUM_RST 5'h00
`define IVP_TAKE_RST 1'b0
`define IVP_AFTER_RST 1'b1
`define IVP_OFS_EXT_IRQ_ZERO 12'h001
`define IVP_OFS_EXT_IRQ_ONE 12'h002
`define IVP_OFS_PIN_CHG_ZERO 12'h003
`define IVP_OFS_PIN_CHG_ONE 12'h004
`define IVP_OFS_PIN_CHG_TWO 12'h005
`define IVP_OFS_WATCHDOG 12'h006
`define IVP_OFS_T2_MATCH_A 12'h007
`define IVP_OFS_T2_MATCH_B 12'h008
`define IVP_OFS_T2_WRAP 12'h009
`define IVP_OFS_T1_CAPTURE 12'h00A
`define IVP_OFS_T1_MATCH_A 12'h00B
`define IVP_OFS_T1_MATCH_B 12'h00C
`define IVP_OFS_T1_WRAP 12'h00D
`define IVP_OFS_T0_MATCH_A 12'h00E
`define IVP_OFS_T0_MATCH_B 12'h00F
`define IVP_OFS_T0_WRAP 12'h010
`define IVP_OFS_SERIAL_DONE 12'h011
`define IVP_OFS_UART_RX_DONE 12'h012
`define IVP_OFS_UART_TX_EMPTY 12'h013
`define IVP_OFS_UART_TX_DONE 12'h014
`define IVP_OFS_CONVERTER 12'h015
`define IVP_OFS_EEPROM_IDLE 12'h016
`define IVP_OFS_COMPARATOR 12'h017
`define IVP_OFS_TWO_WIRE 12'h018
`define IVP_OFS_PROG_STORE 12'h019
`endif

// ---- ivp_vector_gen.v ----
// reset and interrupt vector address generator for the core fetch unit
// assumes requests are synchronous levels from peripherals
// Overview of operation
// R1: unprogrammed fuse: reset starts at 0x000
// R2: programmed fuse: reset at boot loader address
// R3: fuse value 1 unprogrammed, 0 programmed
// R4: select bit moves table to boot+0x001
// R5: relocated target is table address plus boot
// R6: external, pin change, watchdog at 0x001-0x006
// R7: timer vectors occupy 0x007 through 0x010
// R8: serial through program-store vectors 0x011-0x019
// R9: only enabled sources are ever vectored
// R10: lowest vector number wins when several pend
`include "ivp_defs.vh"
module ivp_vector_gen
(
    input wire clk,
    input wire rst,
    input wire boot_reset_fuse,
    input wire [11:0] boot_start_addr,
    input wire vector_base_select,
    input wire global_irq_enable,
    input wire [24:0] irq_pending,
    input wire [24:0] irq_enable,
    input wire irq_ack,
    output reg [11:0] reset_target_r,
    output reg [11:0] vector_target_r,
    output reg [4:0] vector_num_r,
    output reg irq_take_r,
    output reg after_reset_r
);
    // source bit i (0..24) corresponds to vector number i+2:
    // 0 ext_irq_zero, 1 ext_irq_one, 2..4 pin_change_irq_zero..two,
    // 5 watchdog_timeout_irq, 6..8 timer_two_match_a/b/wrap,
    // 9..12 timer_one_capture/match_a/match_b/wrap,
    // 13..15 timer_zero_match_a/b/wrap, 16 serial_xfer_done_irq,
    // 17..19 uart rx/tx_buffer_empty/tx done, 20 converter,
    // 21 eeprom_idle_irq, 22 comparator, 23 two_wire_irq,
    // 24 program_store_idle_irq
    wire [24:0] active;
    wire ext_irq_zero;
    wire ext_irq_one;
    wire pin_change_irq_zero;
    wire pin_change_irq_one;
    wire pin_change_irq_two;
    wire watchdog_timeout_irq;
    wire timer_two_match_a;
    wire timer_two_match_b;
    wire timer_two_wrap;
    wire timer_one_capture;
    wire timer_one_match_a;
    wire timer_one_match_b;
    wire timer_one_wrap;
    wire timer_zero_match_a;
    wire timer_zero_match_b;
    wire timer_zero_wrap;
    wire serial_xfer_done_irq;
    wire uart_rx_done_irq;
    wire uart_tx_buffer_empty_irq;
    wire uart_tx_done_irq;
    wire converter_done_irq;
    wire eeprom_idle_irq;
    wire comparator_irq;
    wire two_wire_irq;
    wire program_store_idle_irq;
    reg [4:0] idx_nxt;
    reg found_nxt;
    reg [11:0] ofs_nxt;
    reg [11:0] base_nxt;
    reg [11:0] reset_nxt;

    assign active = irq_pending & irq_enable; // [R9]
    assign ext_irq_zero = active[0];
    assign ext_irq_one = active[1];
    assign pin_change_irq_zero = active[2];
    assign pin_change_irq_one = active[3];
    assign pin_change_irq_two = active[4];
    assign watchdog_timeout_irq = active[5];
    assign timer_two_match_a = active[6];
    assign timer_two_match_b = active[7];
    assign timer_two_wrap = active[8];
    assign timer_one_capture = active[9];
    assign timer_one_match_a = active[10];
    assign timer_one_match_b = active[11];
    assign timer_one_wrap = active[12];
    assign timer_zero_match_a = active[13];
    assign timer_zero_match_b = active[14];
    assign timer_zero_wrap = active[15];
    assign serial_xfer_done_irq = active[16];
    assign uart_rx_done_irq = active[17];
    assign uart_tx_buffer_empty_irq = active[18];
    assign uart_tx_done_irq = active[19];
    assign converter_done_irq = active[20];
    assign eeprom_idle_irq = active[21];
    assign comparator_irq = active[22];
    assign two_wire_irq = active[23];
    assign program_store_idle_irq = active[24];

    // fixed priority: first match in vector order wins
    always @*
    begin
        idx_nxt = 5'h00;
        found_nxt = 1'b1;
        if (ext_irq_zero) // [R10]
        begin
            idx_nxt = 5'h00;
        end
        else if (ext_irq_one)
        begin
            idx_nxt = 5'h01;
        end
        else if (pin_change_irq_zero)
        begin
            idx_nxt = 5'h02;
        end
        else if (pin_change_irq_one)
        begin
            idx_nxt = 5'h03;
        end
        else if (pin_change_irq_two)
        begin
            idx_nxt = 5'h04;
        end
        else if (watchdog_timeout_irq)
        begin
            idx_nxt = 5'h05;
        end
        else if (timer_two_match_a)
        begin
            idx_nxt = 5'h06;
        end
        else if (timer_two_match_b)
        begin
            idx_nxt = 5'h07;
        end
        else if (timer_two_wrap)
        begin
            idx_nxt = 5'h08;
        end
        else if (timer_one_capture)
        begin
            idx_nxt = 5'h09;
        end
        else if (timer_one_match_a)
        begin
            idx_nxt = 5'h0A;
        end
        else if (timer_one_match_b)
        begin
            idx_nxt = 5'h0B;
        end
        else if (timer_one_wrap)
        begin
            idx_nxt = 5'h0C;
        end
        else if (timer_zero_match_a)
        begin
            idx_nxt = 5'h0D;
        end
        else if (timer_zero_match_b)
        begin
            idx_nxt = 5'h0E;
        end
        else if (timer_zero_wrap)
        begin
            idx_nxt = 5'h0F;
        end
        else if (serial_xfer_done_irq)
        begin
            idx_nxt = 5'h10;
        end
        else if (uart_rx_done_irq)
        begin
            idx_nxt = 5'h11;
        end
        else if (uart_tx_buffer_empty_irq)
        begin
            idx_nxt = 5'h12;
        end
        else if (uart_tx_done_irq)
        begin
            idx_nxt = 5'h13;
        end
        else if (converter_done_irq)
        begin
            idx_nxt = 5'h14;
        end
        else if (eeprom_idle_irq)
        begin
            idx_nxt = 5'h15;
        end
        else if (comparator_irq)
        begin
            idx_nxt = 5'h16;
        end
        else if (two_wire_irq)
        begin
            idx_nxt = 5'h17;
        end
        else if (program_store_idle_irq)
        begin
            idx_nxt = 5'h18;
        end
        else
        begin
            found_nxt = 1'b0;
        end
    end

    // table offset of the winning source
    always @*
    begin
        case (idx_nxt)
            5'h00: ofs_nxt = `IVP_OFS_EXT_IRQ_ZERO; // [R6]
            5'h01: ofs_nxt = `IVP_OFS_EXT_IRQ_ONE; // [R6]
            5'h02: ofs_nxt = `IVP_OFS_PIN_CHG_ZERO; // [R6]
            5'h03: ofs_nxt = `IVP_OFS_PIN_CHG_ONE; // [R6]
            5'h04: ofs_nxt = `IVP_OFS_PIN_CHG_TWO; // [R6]
            5'h05: ofs_nxt = `IVP_OFS_WATCHDOG; // [R6]
            5'h06: ofs_nxt = `IVP_OFS_T2_MATCH_A; // [R7]
            5'h07: ofs_nxt = `IVP_OFS_T2_MATCH_B; // [R7]
            5'h08: ofs_nxt = `IVP_OFS_T2_WRAP; // [R7]
            5'h09: ofs_nxt = `IVP_OFS_T1_CAPTURE; // [R7]
            5'h0A: ofs_nxt = `IVP_OFS_T1_MATCH_A; // [R7]
            5'h0B: ofs_nxt = `IVP_OFS_T1_MATCH_B; // [R7]
            5'h0C: ofs_nxt = `IVP_OFS_T1_WRAP; // [R7]
            5'h0D: ofs_nxt = `IVP_OFS_T0_MATCH_A; // [R7]
            5'h0E: ofs_nxt = `IVP_OFS_T0_MATCH_B; // [R7]
            5'h0F: ofs_nxt = `IVP_OFS_T0_WRAP; // [R7]
            5'h10: ofs_nxt = `IVP_OFS_SERIAL_DONE; // [R8]
            5'h11: ofs_nxt = `IVP_OFS_UART_RX_DONE; // [R8]
            5'h12: ofs_nxt = `IVP_OFS_UART_TX_EMPTY; // [R8]
            5'h13: ofs_nxt = `IVP_OFS_UART_TX_DONE; // [R8]
            5'h14: ofs_nxt = `IVP_OFS_CONVERTER; // [R8]
            5'h15: ofs_nxt = `IVP_OFS_EEPROM_IDLE; // [R8]
            5'h16: ofs_nxt = `IVP_OFS_COMPARATOR; // [R8]
            5'h17: ofs_nxt = `IVP_OFS_TWO_WIRE; // [R8]
            5'h18: ofs_nxt = `IVP_OFS_PROG_STORE; // [R8]
            default: ofs_nxt = `IVP_TABLE_OFS;
        endcase
    end

    always @*
    begin
        if (boot_reset_fuse == `IVP_FUSE_PROGRAMMED) // [R3]
            reset_nxt = boot_start_addr; // [R2]
        else
            reset_nxt = `IVP_RESET_OFS; // [R1]
        if (vector_base_select)
            base_nxt = boot_start_addr; // [R4] [R5]
        else
            base_nxt = `IVP_ZERO_BASE; // [R4]
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reset_target_r <= `IVP_RESET_OFS;
            vector_target_r <= `IVP_TABLE_OFS;
            vector_num_r <= `IVP_NUM_RST;
            irq_take_r <= `IVP_TAKE_RST;
            after_reset_r <= `IVP_AFTER_RST;
        end
        else
        begin
            reset_target_r <= reset_nxt;
            after_reset_r <= 1'b0;
            // vector index maps table offsets 0x001..0x019 [R6] [R7] [R8]
            irq_take_r <= found_nxt & global_irq_enable & ~irq_ack; // [R9]
            if (found_nxt)
            begin
                vector_num_r <= idx_nxt + `IVP_NUM_OFS;
                vector_target_r <= base_nxt + ofs_nxt; // [R5]
            end
        end
    end
endmodule // ivp_vector_gen

// ---- ivp_core_model.sv ----
// core: acks each take
module ivp_core(input wire clk,rst,t,output logic a);
timeunit 1ns; timeprecision 1ns;
always @(posedge clk,posedge rst) a<=!rst&&t&&!a;
endmodule // ivp_core

// ---- ivp_monitor.sv ----
// checker for the vector generator: reset target, table, priority, mask
// assumes it is bound to the generator and sees only its ports
module ivp_monitor
(
    input wire clk,
    input wire rst,
    input wire boot_reset_fuse,
    input wire [11:0] boot_start_addr,
    input wire vector_base_select,
    input wire global_irq_enable,
    input wire [24:0] irq_pending,
    input wire [24:0] irq_enable,
    input wire irq_ack,
    input wire [11:0] reset_target_r,
    input wire [11:0] vector_target_r,
    input wire [4:0] vector_num_r,
    input wire irq_take_r,
    input wire after_reset_r
);
    logic [24:0] act_q;

    // enabled requests seen at the previous edge
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            act_q <= '0;
        else
            act_q <= irq_pending & irq_enable;
    end

    sequence s_req;
        !after_reset_r && global_irq_enable && !irq_ack &&
            (|(irq_pending & irq_enable));
    endsequence

    sequence s_acked;
        irq_ack;
    endsequence

    property p_tgt;
        @(posedge clk) disable iff (rst)
        irq_take_r |-> vector_target_r == 12'(vector_num_r) - 12'h001 +
            ($past(vector_base_select) ? $past(boot_start_addr) : 12'h000);
    endproperty

    property p_rst_app;
        @(posedge clk) disable iff (rst)
        !after_reset_r && $past(boot_reset_fuse) |->
            reset_target_r == 12'h000;
    endproperty

    property p_rst_boot;
        @(posedge clk) disable iff (rst)
        !after_reset_r && !$past(boot_reset_fuse) |->
            reset_target_r == $past(boot_start_addr);
    endproperty

    property p_take;
        @(posedge clk) disable iff (rst)
        s_req |=> irq_take_r;
    endproperty

    property p_ack;
        @(posedge clk) disable iff (rst)
        s_acked |=> !irq_take_r;
    endproperty

    property p_mask;
        @(posedge clk) disable iff (rst)
        irq_take_r |-> $past(global_irq_enable) && !$past(irq_ack);
    endproperty

    property p_win;
        @(posedge clk) disable iff (rst)
        irq_take_r |-> act_q[vector_num_r - 5'h02];
    endproperty

    property p_prio;
        @(posedge clk) disable iff (rst)
        irq_take_r |-> (act_q &
            ((25'h0000001 << (vector_num_r - 5'h02)) - 25'h0000001))
            == 25'h0000000;
    endproperty

    a_tgt: assert property (p_tgt) else $error("bad vector target");
    a_rst_app: assert property (p_rst_app)
        else $error("reset target not zero");
    a_rst_boot: assert property (p_rst_boot)
        else $error("reset target not boot start");
    a_take: assert property (p_take)
        else $error("enabled request not taken");
    a_ack: assert property (p_ack) else $error("take after ack");
    a_mask: assert property (p_mask) else $error("masked take");
    a_win: assert property (p_win)
        else $error("winner not an enabled request");
    a_prio: assert property (p_prio)
        else $error("lower vector was pending");
endmodule // ivp_monitor

bind ivp_vector_gen ivp_monitor i_mon (.*);

// ---- interrupt_vector_placement_bench.sv ----
// bench: reset checks, table of vector cases, then ack and second reset cases by hand
// assumes the core model and the bound checker are compiled with it
module interrupt_vector_placement_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic sel;
        logic gie;
        logic [24:0] en;
        logic [24:0] pend;
        logic take;
        logic [4:0] num;
        logic [11:0] tgt;
    } ivp_row_t;
    localparam logic [24:0] all_on = 25'h1FFFFFF;
    localparam logic [24:0] all_off = 25'h0000000;
    localparam logic [24:0] no_bit3 = 25'h1FFFFF7;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fuse = 1'b1;
    logic sel = 1'b0;
    logic gie = 1'b1;
    logic [11:0] boot = 12'hC00;
    logic [24:0] en = 25'h1FFFFFF;
    logic [24:0] pend = 25'h0000000;
    logic ack;
    logic take;
    logic after;
    logic [4:0] num;
    logic [11:0] rt;
    logic [11:0] vt;
    ivp_row_t rows [0:15];
    int num_errors = 0;
    int check_count = 0;

    ivp_vector_gen i_dut (
        .clk(clk),
        .rst(rst),
        .boot_reset_fuse(fuse),
        .boot_start_addr(boot),
        .vector_base_select(sel),
        .global_irq_enable(gie),
        .irq_pending(pend),
        .irq_enable(en),
        .irq_ack(ack),
        .reset_target_r(rt),
        .vector_target_r(vt),
        .vector_num_r(num),
        .irq_take_r(take),
        .after_reset_r(after)
    );

    ivp_core i_core (
        .clk(clk),
        .rst(rst),
        .t(take),
        .a(ack)
    );

    task automatic chk(input logic [11:0] seen, input logic [11:0] want);
        check_count++;
        if (seen !== want)
        begin
            num_errors++;
            $display("Error %0t: got %h, want %h", $time, seen, want);
        end
    endtask

    task end_of_test;
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        forever #4 clk = ~clk;
    end

    initial
    begin
        rows[0] = '{1'b0, 1'b1, all_on, 25'h0000001, 1'b1, 5'h02, 12'h001};
        rows[1] = '{1'b0, 1'b1, all_on, 25'h0000002, 1'b1, 5'h03, 12'h002};
        rows[2] = '{1'b0, 1'b1, all_on, 25'h0000004, 1'b1, 5'h04, 12'h003};
        rows[3] = '{1'b0, 1'b1, all_on, 25'h0000020, 1'b1, 5'h07, 12'h006};
        rows[4] = '{1'b0, 1'b1, all_on, 25'h0000040, 1'b1, 5'h08, 12'h007};
        rows[5] = '{1'b0, 1'b1, all_on, 25'h0000200, 1'b1, 5'h0B, 12'h00A};
        rows[6] = '{1'b0, 1'b1, all_on, 25'h0008000, 1'b1, 5'h11, 12'h010};
        rows[7] = '{1'b0, 1'b1, all_on, 25'h0010000, 1'b1, 5'h12, 12'h011};
        rows[8] = '{1'b0, 1'b1, all_on, 25'h1000000, 1'b1, 5'h1A, 12'h019};
        rows[9] = '{1'b1, 1'b1, all_on, 25'h0000001, 1'b1, 5'h02, 12'hC01};
        rows[10] = '{1'b1, 1'b1, all_on, 25'h1000000, 1'b1, 5'h1A, 12'hC19};
        rows[11] = '{1'b0, 1'b1, all_on, 25'h0100008, 1'b1, 5'h05, 12'h004};
        rows[12] = '{1'b0, 1'b1, no_bit3, 25'h0100008, 1'b1, 5'h16, 12'h015};
        rows[13] = '{1'b0, 1'b0, all_on, 25'h0000002, 1'b0, 5'h03, 12'h002};
        rows[14] = '{1'b0, 1'b1, all_off, all_on, 1'b0, 5'h03, 12'h002};
        rows[15] = '{1'b1, 1'b1, all_on, 25'h0003000, 1'b1, 5'h0E, 12'hC0D};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({11'h000, after}, 12'h001);
        chk(rt, 12'h000);
        @(negedge clk);
        chk({11'h000, after}, 12'h000);
        chk(rt, 12'h000);
        for (int r = 0; r < 16; r++)
        begin
            @(posedge clk);
            sel <= rows[r].sel;
            gie <= rows[r].gie;
            en <= rows[r].en;
            pend <= rows[r].pend;
            @(posedge clk);
            @(negedge clk);
            chk({11'h000, take}, {11'h000, rows[r].take});
            chk({7'h00, num}, {7'h00, rows[r].num});
            chk(vt, rows[r].tgt);
            @(posedge clk);
            pend <= 25'h0000000;
            repeat (3) @(posedge clk);
        end
        // ack masks exactly one cycle of take
        @(posedge clk);
        sel <= 1'b0;
        pend <= 25'h0000001;
        @(posedge clk);
        @(negedge clk);
        chk({11'h000, take}, 12'h001);
        @(posedge clk);
        @(posedge clk);
        @(negedge clk);
        chk({11'h000, take}, 12'h000);
        @(posedge clk);
        @(negedge clk);
        chk({11'h000, take}, 12'h001);
        @(posedge clk);
        pend <= 25'h0000000;
        repeat (3) @(posedge clk);
        // second reset with fuse programmed and another boot start
        fuse <= 1'b0;
        boot <= 12'h800;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({11'h000, after}, 12'h001);
        chk(rt, 12'h000);
        @(negedge clk);
        chk({11'h000, after}, 12'h000);
        chk(rt, 12'h800);
        @(posedge clk);
        sel <= 1'b1;
        pend <= 25'h0000002;
        @(posedge clk);
        @(negedge clk);
        chk(vt, 12'h802);
        chk(rt, 12'h800);
        @(posedge clk);
        sel <= 1'b0;
        pend <= 25'h1000000;
        @(posedge clk);
        @(negedge clk);
        chk(vt, 12'h019);
        end_of_test;
    end
endmodule // interrupt_vector_placement_bench
